/* File: psid_regs.svh */
// Purpose: offsets, bit positions and reset values of the status and id words
// Assumes: five-bit management register addresses, sixteen-bit words
// Notes:   definitions only, included by the package and the top module
`ifndef PSID_REGS_SVH
`define PSID_REGS_SVH

// management register addresses
`define PSID_ADDR_BASIC   5'h01
`define PSID_ADDR_ID_HI   5'h02
`define PSID_ADDR_ID_LO   5'h03
`define PSID_ADDR_VEND    5'h10
`define PSID_ADDR_INT     5'h12

// basic status word bit positions
`define PSID_B_T4         15
`define PSID_B_ABIL_HI    14
`define PSID_B_ABIL_LO    11
`define PSID_B_NOPRE      6
`define PSID_B_NEGDONE    5
`define PSID_B_RFAULT     4
`define PSID_B_ANABLE     3
`define PSID_B_LINK       2
`define PSID_B_JABBER     1
`define PSID_B_EXTCAP     0

// vendor status word bit positions
`define PSID_V_RXERR      13
`define PSID_V_CHAN       10
`define PSID_V_DESCR      9
`define PSID_V_INTPIN     7
`define PSID_V_JABBER     5
`define PSID_V_LOOP       3
`define PSID_V_DUPLEX     2
`define PSID_V_LINK       0

// identifier split between the two id words
`define PSID_OUI_HI_MSB   21
`define PSID_OUI_HI_LSB   6
`define PSID_OUI_LO_MSB   5

// second id word fields
`define PSID_I_OUI_MSB    15
`define PSID_I_OUI_LSB    10
`define PSID_I_MODEL_MSB  9
`define PSID_I_MODEL_LSB  4
`define PSID_I_REV_MSB    3
`define PSID_I_REV_LSB    0

// reset values
`define PSID_BASIC_RST    16'h0061
`define PSID_VEND_RST     16'h0004

`endif

/* File: psid_pkg.sv */
// Purpose: shared types and the address decode of the status and id bank
// Assumes: psid_regs.svh holds every register address the decode compares against
// Notes:   nothing here is imported, users write psid_pkg::name
`include "psid_regs.svh"
package psid_pkg;

    typedef logic [4:0]  psid_addr_t;  // management register address
    typedef logic [15:0] psid_word_t;  // one management word

    // which word a read addresses
    typedef enum logic [2:0]
    {
        PSID_SEL_NONE  = 3'b000,
        PSID_SEL_BASIC = 3'b001,
        PSID_SEL_ID_HI = 3'b010,
        PSID_SEL_ID_LO = 3'b011,
        PSID_SEL_VEND  = 3'b100,
        PSID_SEL_INT   = 3'b101
    } psid_sel_e;

    // address to word select, unmapped gives none
    function automatic psid_sel_e psid_decode(input psid_addr_t addr);
        psid_sel_e sel;
        sel = PSID_SEL_NONE;
        if (addr == `PSID_ADDR_BASIC)
            sel = PSID_SEL_BASIC;
        else if (addr == `PSID_ADDR_ID_HI)
            sel = PSID_SEL_ID_HI;
        else if (addr == `PSID_ADDR_ID_LO)
            sel = PSID_SEL_ID_LO;
        else if (addr == `PSID_ADDR_VEND)
            sel = PSID_SEL_VEND;
        else if (addr == `PSID_ADDR_INT)
            sel = PSID_SEL_INT;
        return sel;
    endfunction : psid_decode

endpackage : psid_pkg

/* File: psid_sync.sv */
// Purpose: two flip-flop synchroniser for a group of level inputs
// Assumes: each bit is a slow level, no word coherence is needed
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module psid_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_srst,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] stage1;       // metastable stage
    logic [W-1:0] stage2;       // settled stage
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    // a zero width group has nothing to carry
    if (W < 1)
    begin : g_bad_width
        $error("psid_sync width must be at least one");
    end

    // next values, frozen while the enable is low
    always_comb
    begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (i_clk_en)
        begin
            next_stage1 = i_async;
            next_stage2 = stage1;
        end
    end

    // registers only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_sync = stage2;

endmodule : psid_sync

/* File: psid_flag.sv */
// Purpose: sticky flag set by hardware, cleared by a register read
// Assumes: set and clear are same-clock single-cycle terms
// Notes:   a set in the clearing cycle wins so no event is lost
`timescale 1ns/1ps
module psid_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_clk_en,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);

    logic flag;       // held flag
    logic next_flag;

    // set has priority over clear
    always_comb
    begin
        next_flag = flag;
        if (i_clk_en)
        begin
            if (i_set)
                next_flag = 1'b1;
            else if (i_clear)
                next_flag = 1'b0;
        end
    end

    // register only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            flag <= RST_VAL;
        else
            flag <= next_flag;
    end

    assign o_flag = flag;

endmodule : psid_flag

/* File: psid_status_id.sv */
// Purpose: read side of the basic status, id and vendor status words
// Assumes: a frame engine outside decodes management frames into reads
// Notes:   read data appears one enabled edge after the read strobe
`timescale 1ns/1ps
`include "psid_regs.svh"
module psid_status_id #(
    parameter logic [21:0] OUI   = 22'h1A5C33, // arbitrary value
    parameter logic [5:0]  MODEL = 6'h2D,      // arbitrary value
    parameter logic [3:0]  REV   = 4'h3        // arbitrary value
) (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_clk_en,
    input  wire logic                    i_rd_strobe,
    input  wire psid_pkg::psid_addr_t    i_rd_addr,
    output psid_pkg::psid_word_t         o_rd_data,
    output logic                         o_rd_valid,
    output logic                         o_no_preamble_accept,
    input  wire logic                    i_neg_done,
    input  wire logic                    i_remote_fault,
    input  wire logic                    i_jabber,
    input  wire logic                    i_rx_error,
    input  wire logic                    i_link_up,
    input  wire logic                    i_chan_good,
    input  wire logic                    i_descr_lock,
    input  wire logic                    i_duplex_full,
    input  wire logic                    i_loopback,
    input  wire logic                    i_int_pin_n
);

    // synchroniser group order: link, chan, descr, duplex, loop, int_n
    localparam logic [5:0] SYNC_RST = 6'b000101;

    logic [5:0]           async_in;    // pin-side levels
    logic [5:0]           sync_out;    // settled levels
    logic                 link_s;      // link level, settled
    logic                 chan_s;      // channel good, settled
    logic                 descr_s;     // descrambler lock, settled
    logic                 duplex_s;    // full duplex, settled
    logic                 loop_s;      // loopback, settled
    logic                 int_n_s;     // interrupt pin, settled
    psid_pkg::psid_sel_e  rd_sel;      // decoded read target
    logic                 rd_go;       // read taken this edge
    logic                 rd_basic;    // basic word read
    logic                 rd_vend;     // vendor word read
    logic                 rd_int;      // interrupt status read
    logic                 link_q;      // link state register
    logic                 neg_done_q;  // negotiation done register
    logic                 duplex_q;    // duplex status register
    logic                 loop_q;      // loopback status register
    logic                 next_link_q;
    logic                 next_neg_done_q;
    logic                 next_duplex_q;
    logic                 next_loop_q;
    logic                 rfault;      // sticky remote fault
    logic                 jabber;      // sticky jabber
    logic                 rxerr;       // sticky receive error
    logic                 intpin;      // sticky interrupt pin
    logic                 chan_drop;   // channel good dropped since read
    logic                 descr_drop;  // lock dropped since read
    psid_pkg::psid_word_t basic_word;  // assembled basic status
    psid_pkg::psid_word_t id_hi_word;  // first id word
    psid_pkg::psid_word_t id_lo_word;  // second id word
    psid_pkg::psid_word_t vend_word;   // assembled vendor status
    psid_pkg::psid_word_t rd_data;     // read data register
    psid_pkg::psid_word_t next_rd_data;
    logic                 rd_valid;    // read answer strobe
    logic                 next_rd_valid;

    // levels from other domains settle before any logic reads them
    assign async_in = {i_link_up, i_chan_good, i_descr_lock,
                       i_duplex_full, i_loopback, i_int_pin_n};

    psid_sync #(
        .W       (6),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_async   (async_in),
        .o_sync    (sync_out)
    );

    assign {link_s, chan_s, descr_s, duplex_s, loop_s, int_n_s} = sync_out;

    // read decode, shared by the data path and clear-on-read terms
    assign rd_sel   = psid_pkg::psid_decode(i_rd_addr);
    assign rd_go    = i_clk_en & i_rd_strobe;
    assign rd_basic = rd_go & (rd_sel == psid_pkg::PSID_SEL_BASIC);
    assign rd_vend  = rd_go & (rd_sel == psid_pkg::PSID_SEL_VEND);
    assign rd_int   = rd_go & (rd_sel == psid_pkg::PSID_SEL_INT);

    // live status registers follow their sources
    always_comb
    begin
        next_link_q     = link_q;
        next_neg_done_q = neg_done_q;
        next_duplex_q   = duplex_q;
        next_loop_q     = loop_q;
        if (i_clk_en)
        begin
            next_link_q     = link_s;
            next_neg_done_q = i_neg_done;
            next_duplex_q   = duplex_s;
            next_loop_q     = loop_s;
        end
    end

    // negotiation done and duplex come out of reset at one
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            link_q     <= 1'b0;
            neg_done_q <= 1'b1;
            duplex_q   <= 1'b1;
            loop_q     <= 1'b0;
        end
        else
        begin
            link_q     <= next_link_q;
            neg_done_q <= next_neg_done_q;
            duplex_q   <= next_duplex_q;
            loop_q     <= next_loop_q;
        end
    end

    // fault and jabber stay until software has seen them
    psid_flag #(.RST_VAL(1'b0)) u_rfault (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (i_remote_fault),
        .i_clear   (rd_basic),
        .o_flag    (rfault)
    );

    psid_flag #(.RST_VAL(1'b0)) u_jabber (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (i_jabber),
        .i_clear   (rd_basic),
        .o_flag    (jabber)
    );

    // receive error held until the vendor word is read
    psid_flag #(.RST_VAL(1'b0)) u_rxerr (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (i_rx_error),
        .i_clear   (rd_vend),
        .o_flag    (rxerr)
    );

    // pin is active low; held while asserted, cleared by 0x12 read
    psid_flag #(.RST_VAL(1'b0)) u_intpin (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (~int_n_s),
        .i_clear   (rd_int),
        .o_flag    (intpin)
    );

    // latch low kept as a drop flag; reset reads zero until first read
    psid_flag #(.RST_VAL(1'b1)) u_chan (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (~chan_s),
        .i_clear   (rd_vend),
        .o_flag    (chan_drop)
    );

    psid_flag #(.RST_VAL(1'b1)) u_descr (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_set     (~descr_s),
        .i_clear   (rd_vend),
        .o_flag    (descr_drop)
    );

    // frame engine is told preamble-less frames are fine
    assign o_no_preamble_accept = 1'b1;

    // basic status word, fixed bits are constants
    always_comb
    begin
        basic_word                                   = 16'h0000;
        basic_word[`PSID_B_T4]                       = 1'b0;
        basic_word[`PSID_B_ABIL_HI:`PSID_B_ABIL_LO]  = 4'h0;
        basic_word[`PSID_B_NOPRE]                    = 1'b1;
        basic_word[`PSID_B_NEGDONE]                  = neg_done_q;
        basic_word[`PSID_B_RFAULT]                   = rfault;
        basic_word[`PSID_B_ANABLE]                   = 1'b0;
        basic_word[`PSID_B_LINK]                     = link_q;
        basic_word[`PSID_B_JABBER]                   = jabber;
        basic_word[`PSID_B_EXTCAP]                   = 1'b1;
    end

    // id words are wired constants
    assign id_hi_word = OUI[`PSID_OUI_HI_MSB:`PSID_OUI_HI_LSB];
    assign id_lo_word = {OUI[`PSID_OUI_LO_MSB:0],
                         MODEL,
                         REV};

    // vendor word, reserved bits read zero
    always_comb
    begin
        vend_word                  = 16'h0000;
        vend_word[`PSID_V_RXERR]   = rxerr;
        vend_word[`PSID_V_CHAN]    = ~chan_drop;
        vend_word[`PSID_V_DESCR]   = ~descr_drop;
        vend_word[`PSID_V_INTPIN]  = intpin;
        vend_word[`PSID_V_JABBER]  = jabber;
        vend_word[`PSID_V_LOOP]    = loop_q;
        vend_word[`PSID_V_DUPLEX]  = duplex_q;
        vend_word[`PSID_V_LINK]    = link_q;
    end

    // read mux; the word is taken before any clear lands
    always_comb
    begin
        next_rd_data  = rd_data;
        next_rd_valid = rd_valid;
        if (i_clk_en)
        begin
            next_rd_valid = i_rd_strobe;
            if (i_rd_strobe)
            begin
                case (rd_sel)
                    psid_pkg::PSID_SEL_BASIC: next_rd_data = basic_word;
                    psid_pkg::PSID_SEL_ID_HI: next_rd_data = id_hi_word;
                    psid_pkg::PSID_SEL_ID_LO: next_rd_data = id_lo_word;
                    psid_pkg::PSID_SEL_VEND:  next_rd_data = vend_word;
                    default:                  next_rd_data = 16'h0000;
                endcase
            end
        end
    end

    // read answer registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    assign o_rd_data  = rd_data;
    assign o_rd_valid = rd_valid;

    // checks
    sequence s_rd_basic;
        i_clk_en && i_rd_strobe && (rd_sel == psid_pkg::PSID_SEL_BASIC);
    endsequence

    sequence s_rd_vend;
        i_clk_en && i_rd_strobe && (rd_sel == psid_pkg::PSID_SEL_VEND);
    endsequence

    sequence s_rd_idlo;
        i_clk_en && i_rd_strobe && (rd_sel == psid_pkg::PSID_SEL_ID_LO);
    endsequence

    property p_t4_zero;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> o_rd_valid && !o_rd_data[15];
    endproperty
    a_t4_zero: assert property (p_t4_zero) else $error("t4 bit set");

    property p_abil_zero;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> o_rd_data[14:11] == 4'h0;
    endproperty
    a_abil_zero: assert property (p_abil_zero) else $error("ability set");

    property p_nopre;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> o_rd_data[6] && o_no_preamble_accept;
    endproperty
    a_nopre: assert property (p_nopre) else $error("preamble bit low");

    property p_neg_rst;
        @(posedge i_sys_clk) disable iff (i_srst)
        $past(i_srst) ##0 s_rd_basic |=> o_rd_data[5];
    endproperty
    a_neg_rst: assert property (p_neg_rst) else $error("neg done not one");

    property p_rfault;
        @(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && i_remote_fault |=> rfault && basic_word[4];
    endproperty
    a_rfault: assert property (p_rfault) else $error("fault lost");

    property p_an_zero;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> !o_rd_data[3] && o_rd_data[0];
    endproperty
    a_an_zero: assert property (p_an_zero) else $error("an bit set");

    property p_link;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> o_rd_data[2] == $past(link_s, 2);
    endproperty
    a_link: assert property (p_link) else $error("link bit wrong");

    property p_jabber;
        @(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && i_jabber |=> jabber && vend_word[5];
    endproperty
    a_jabber: assert property (p_jabber) else $error("jabber lost");

    property p_extcap;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_basic |=> o_rd_data[0];
    endproperty
    a_extcap: assert property (p_extcap) else $error("extcap low");

    property p_id_hi;
        @(posedge i_sys_clk) disable iff (i_srst)
        rd_go && (rd_sel == psid_pkg::PSID_SEL_ID_HI) |=> o_rd_data == OUI[21:6];
    endproperty
    a_id_hi: assert property (p_id_hi) else $error("id high wrong");

    property p_oui_lo;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_idlo |=> o_rd_data[15:10] == OUI[5:0];
    endproperty
    a_oui_lo: assert property (p_oui_lo) else $error("oui low wrong");

    property p_model;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_idlo |=> o_rd_data[9:4] == MODEL;
    endproperty
    a_model: assert property (p_model) else $error("model wrong");

    property p_rev;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_idlo |=> o_rd_data[3:0] == REV;
    endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");

    property p_vend_rst;
        @(posedge i_sys_clk) disable iff (i_srst)
        $past(i_srst) |-> vend_word == 16'h0004;
    endproperty
    a_vend_rst: assert property (p_vend_rst) else $error("vendor reset");

    property p_rxerr_clr;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_vend ##0 !i_rx_error |=> !rxerr;
    endproperty
    a_rxerr_clr: assert property (p_rxerr_clr) else $error("rx err kept");

    property p_int_clr;
        @(posedge i_sys_clk) disable iff (i_srst)
        rd_int && int_n_s |=> !vend_word[7];
    endproperty
    a_int_clr: assert property (p_int_clr) else $error("int not cleared");

    property p_chan_low;
        @(posedge i_sys_clk) disable iff (i_srst)
        i_clk_en && !chan_s |=> !vend_word[10] ##1 (!vend_word[10] || $past(rd_vend));
    endproperty
    a_chan_low: assert property (p_chan_low) else $error("chan not low");

    property p_descr;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_vend ##0 descr_s |=> vend_word[9];
    endproperty
    a_descr: assert property (p_descr) else $error("lock not shown");

    property p_hold;
        @(posedge i_sys_clk) disable iff (i_srst)
        rfault && !rd_basic |=> rfault;
    endproperty
    a_hold: assert property (p_hold) else $error("fault dropped");

    property p_mirror;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_rd_vend |=> o_rd_data[0] == $past(link_q) && o_rd_data[5] == $past(jabber);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror wrong");

endmodule : psid_status_id

/* File: psid_mgmt_model.sv */
// Purpose: management controller model that issues register reads
// Assumes: reads only, one strobe pulse per read
// Notes:   drives at the falling edge, waits at most 4 cycles for valid
`timescale 1ns/1ps
module psid_mgmt_model (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rd_valid,
    input  wire psid_pkg::psid_word_t i_rd_data,
    output logic                      o_rd_strobe,
    output psid_pkg::psid_addr_t      o_rd_addr
);
    // idle bus starts released
    initial
    begin
        o_rd_strobe = 1'b0;
        o_rd_addr   = 5'h1F;
    end

    // one read, strobe held across exactly one rising edge
    task automatic read(input psid_pkg::psid_addr_t a, output psid_pkg::psid_word_t d,
                        output logic ok);
        int n;
        @(negedge i_sys_clk);
        o_rd_strobe = 1'b1;
        o_rd_addr   = a;
        @(negedge i_sys_clk);
        o_rd_strobe = 1'b0;
        o_rd_addr   = ~a; // released address never repeats the last one
        n = 0;
        // bounded wait, a lost answer shows as ok low
        while (i_rd_valid !== 1'b1 && n < 4)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        ok = (i_rd_valid === 1'b1);
        d  = i_rd_data;
    endtask : read
endmodule : psid_mgmt_model

/* File: testbench.sv */
// Purpose: self-checking bench of the status and id words
// Assumes: clock enable high except one freeze test, inputs change at the falling edge
// Notes:   async inputs get 5 cycles to pass the synchronisers
`timescale 1ns/1ps
module testbench;
    localparam logic [21:0] OUI   = 22'h2B1D4E; // arbitrary value
    localparam logic [5:0]  MODEL = 6'h15;      // arbitrary value
    localparam logic [3:0]  REV   = 4'h9;       // arbitrary value
    typedef struct { psid_pkg::psid_addr_t a; psid_pkg::psid_word_t d; } psid_row_s;
    logic clk = 1'b0, srst = 1'b1, stb, valid, npre;
    logic neg = 1'b1, rf = 1'b0, jab = 1'b0, rxe = 1'b0, link = 1'b0, chan = 1'b1;
    logic descr = 1'b1, dup = 1'b1, loopb = 1'b0, intn = 1'b1, en = 1'b1;
    psid_pkg::psid_addr_t addr;
    psid_pkg::psid_word_t data;
    int fail_count = 0, num_checks = 0;
    // plain reads after reset, latch-low bits re-armed by the first vendor read
    psid_row_s rows [7] = '{'{5'h01, 16'h0061}, '{5'h02, OUI[21:6]},
        '{5'h03, {OUI[5:0], MODEL, REV}}, '{5'h10, 16'h0004}, '{5'h10, 16'h0604},
        '{5'h12, 16'h0000}, '{5'h05, 16'h0000}};

    always #25 clk = ~clk;

    psid_status_id #(.OUI(OUI), .MODEL(MODEL), .REV(REV)) i_psid_status_id (
        .i_sys_clk(clk), .i_srst(srst), .i_clk_en(en), .i_rd_strobe(stb),
        .i_rd_addr(addr), .o_rd_data(data), .o_rd_valid(valid),
        .o_no_preamble_accept(npre), .i_neg_done(neg), .i_remote_fault(rf),
        .i_jabber(jab), .i_rx_error(rxe), .i_link_up(link), .i_chan_good(chan),
        .i_descr_lock(descr), .i_duplex_full(dup), .i_loopback(loopb), .i_int_pin_n(intn));

    psid_mgmt_model i_psid_mgmt_model (.i_sys_clk(clk), .i_rd_valid(valid),
        .i_rd_data(data), .o_rd_strobe(stb), .o_rd_addr(addr));

    // verdict and end of run, shared with the watchdog
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic check(input psid_pkg::psid_word_t seen, input psid_pkg::psid_word_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // read one word, answer must arrive and match
    task automatic rd(input psid_pkg::psid_addr_t a, input psid_pkg::psid_word_t exp);
        psid_pkg::psid_word_t d;
        logic ok;
        i_psid_mgmt_model.read(a, d, ok);
        check({15'h0, ok}, 16'h0001);
        check(d, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // watchdog, the whole sequence needs well under 1000 cycles
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end

    initial
    begin
        idle(4);
        srst = 1'b0;
        check({15'h0, npre}, 16'h0001);
        foreach (rows[k]) rd(rows[k].a, rows[k].d);
        // one-cycle event pulses, vendor read must not clear basic flags
        rf = 1'b1;
        jab = 1'b1;
        rxe = 1'b1;
        idle(1);
        rf = 1'b0;
        jab = 1'b0;
        rxe = 1'b0;
        rd(5'h10, 16'h2624);
        rd(5'h10, 16'h0624);
        rd(5'h01, 16'h0073);
        rd(5'h01, 16'h0061);
        rd(5'h10, 16'h0604);
        // live levels, negotiation done taken directly and the rest through the synchronisers
        link = 1'b1;
        neg = 1'b0;
        loopb = 1'b1;
        dup = 1'b0;
        idle(5);
        rd(5'h01, 16'h0045);
        rd(5'h10, 16'h0609);
        // short drop of both lock levels stays latched low
        chan = 1'b0;
        descr = 1'b0;
        idle(5);
        chan = 1'b1;
        descr = 1'b1;
        idle(5);
        rd(5'h10, 16'h0009);
        rd(5'h10, 16'h0609);
        // pin still low keeps the flag through an interrupt word read
        intn = 1'b0;
        idle(5);
        rd(5'h10, 16'h0689);
        rd(5'h12, 16'h0000);
        intn = 1'b1;
        idle(5);
        rd(5'h10, 16'h0689);
        rd(5'h12, 16'h0000);
        rd(5'h10, 16'h0609);
        // enable low freezes the fault flag, the pulse must leave no trace
        en = 1'b0;
        rf = 1'b1;
        idle(2);
        rf = 1'b0;
        en = 1'b1;
        rd(5'h01, 16'h0045);
        // second reset in mid-run, negotiation input kept low to expose the reset value
        srst = 1'b1;
        idle(3);
        check(data, 16'h0000);
        check({15'h0, valid}, 16'h0000);
        // release and first read share one falling edge, read taken at the first edge
        fork
            begin
                idle(1);
                srst = 1'b0;
            end
            rd(5'h01, 16'h0061);
        join
        idle(5);
        rd(5'h01, 16'h0045);
        rd(5'h10, 16'h0009);
        complete_run();
    end
endmodule : testbench
